// >>> sgmac_ctrl.v
// Control, status and negotiation sequencing of the serial gigabit port
`timescale 1ns/100ps
`default_nettype none
`include "sgmac_defs.vh"
module sgmac_ctrl (
    input wire clk_sys,
    input wire reset_n,
    input wire reg_sel,
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg reg_ack,
    input wire fiber_signal_present,
    input wire serdes_lock,
    input wire partner_config_valid,
    input wire [15:0] partner_config,
    output reg [15:0] local_config,
    output reg config_send,
    output reg loopback_on,
    output reg datapath_reset,
    output reg link_full_duplex,
    output reg [1:0] link_speed
);
    // ****************************************
    // Synchronised pins
    // ****************************************
    wire signal_s;
    wire lock_s;
    wire pvalid_s;
    sgmac_sync u_sig (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(fiber_signal_present),
        .dout(signal_s)
    );
    sgmac_sync u_lock (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(serdes_lock),
        .dout(lock_s)
    );
    sgmac_sync u_pv (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(partner_config_valid),
        .dout(pvalid_s)
    );
    // Each bit synced alone; the word must hold still while valid
    wire [15:0] pcfg_s;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_cfg
            sgmac_sync u_cfg (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .din(partner_config[gi]),
                .dout(pcfg_s[gi])
            );
        end
    endgenerate

    // ****************************************
    // Registers
    // ****************************************
    reg [5:0] port_control;
    reg [15:0] local_ability;
    reg [15:0] partner_ability;
    reg restart_armed;
    reg restart_req;
    wire [31:0] status_word;
    wire wr = reg_sel & reg_wr;
    wire wr_ctl = wr & (reg_addr == `SGMAC_OFF_CONTROL);
    // Restart fires on the falling write of the bit
    wire restart_fall = wr_ctl & restart_armed &
        ~reg_wdata[`SGMAC_CTL_RESTART];
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            port_control <= `SGMAC_CTL_RESET;
            local_ability <= `SGMAC_AB_RESET;
            datapath_reset <= 1'b0;
            restart_armed <= 1'b0;
            restart_req <= 1'b0;
            reg_ack <= 1'b0;
            reg_rdata <= 32'h0;
        end else begin
            reg_ack <= reg_sel & ~reg_ack;
            restart_req <= restart_fall;
            if (wr_ctl) begin
                port_control <= {reg_wdata[`SGMAC_CTL_MASTER],
                    reg_wdata[`SGMAC_CTL_LOOPBACK], 2'h0,
                    reg_wdata[`SGMAC_CTL_RESTART],
                    reg_wdata[`SGMAC_CTL_ENABLE]};
                restart_armed <= reg_wdata[`SGMAC_CTL_RESTART];
            end
            if (wr & (reg_addr == `SGMAC_OFF_LOCAL))
                local_ability <= reg_wdata[15:0];
            // Software must keep this set across a loopback change
            if (wr & (reg_addr == `SGMAC_OFF_RESET))
                datapath_reset <= reg_wdata[`SGMAC_RST_DATAPATH];
            reg_rdata <= 32'h0;
            if (reg_sel & ~reg_wr) begin
                case (reg_addr)
                    `SGMAC_OFF_CONTROL: reg_rdata <=
                        {26'h0, port_control};
                    `SGMAC_OFF_STATUS: reg_rdata <= status_word;
                    `SGMAC_OFF_LOCAL: reg_rdata <= {16'h0, local_ability};
                    `SGMAC_OFF_PARTNER: reg_rdata <=
                        {16'h0, partner_ability};
                    `SGMAC_OFF_RESET: reg_rdata <=
                        {30'h0, datapath_reset, 1'b0};
                    default: reg_rdata <= 32'h0;
                endcase
            end
        end
    end

    // ****************************************
    // Negotiation sequencer
    // ****************************************
    localparam ST_IDLE = 3'h1;
    localparam ST_SEND = 3'h2;
    localparam ST_DONE = 3'h4;
    reg [2:0] state;
    reg [3:0] ack_count;
    wire enable = port_control[`SGMAC_CTL_ENABLE];
    wire master = port_control[`SGMAC_CTL_MASTER];
    // Partner word only trusted once the serializer is locked
    wire rx_ok = pvalid_s & lock_s & pcfg_s[0];
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            ack_count <= 4'h0;
            partner_ability <= 16'h0;
        end else if (!enable | restart_req | datapath_reset) begin
            state <= ST_IDLE;
            ack_count <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    state <= ST_SEND;
                    ack_count <= 4'h0;
                end
                ST_SEND: begin
                    if (rx_ok) begin
                        partner_ability <= pcfg_s;
                        if (pcfg_s[`SGMAC_AB_ACK])
                            ack_count <= ack_count + 4'h1;
                        if (ack_count == `SGMAC_ACK_CYCLES)
                            state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!lock_s)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Resolution and status
    // ****************************************
    // Master trusts its own word; slave follows the partner
    wire [15:0] resolved = master ? local_ability
        : partner_ability;
    wire done = state[2];
    wire fault = done & ~resolved[`SGMAC_AB_DUPLEX] &
        (resolved[`SGMAC_AB_SPD_HI:`SGMAC_AB_SPD_LO] ==
        `SGMAC_SPD_GIG);
    wire link_up = done & resolved[`SGMAC_AB_LINK] & ~fault;
    assign status_word = {26'h0, signal_s, lock_s, 1'b0,
        done, fault, link_up};
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            local_config <= 16'h0;
            config_send <= 1'b0;
            loopback_on <= 1'b0;
            link_full_duplex <= 1'b0;
            link_speed <= 2'h0;
        end else begin
            local_config <= {local_ability[15], state[1] &
                (ack_count != 4'h0), local_ability[13:1], 1'b1};
            config_send <= enable & ~state[0];
            // Clock mux on the datapath follows this level
            loopback_on <= port_control[`SGMAC_CTL_LOOPBACK];
            link_full_duplex <= resolved[`SGMAC_AB_DUPLEX];
            link_speed <= resolved[`SGMAC_AB_SPD_HI:`SGMAC_AB_SPD_LO];
        end
    end
endmodule
`default_nettype wire

// >>> sgmac_defs.vh
// Constants of the serial gigabit port control and status block
// Operation
// - Master role: speed and duplex come from the local ability word.
// - Slave role: speed and duplex come from the partner ability word.
// - Exactly one side of a direct link takes master role.
// - Loopback bit sends both paths onto the transmit clock.
// - Writing one then zero to restart bit restarts negotiation.
// - Enable bit one runs negotiation; zero stops it.
// - Control bits 31 to 6 always read zero.
// - Status bit 5 shows the live fiber signal-detect pin.
// - Status bit 4 shows the live serializer lock pin.
// - Status bit 2 shows negotiation done; valid only under lock.
// - Status bit 1 flags half-duplex gigabit commanded; valid under lock.
// - Status bit 0 shows link up; valid only under lock.
// - Ability words: 15 link, 14 ack, 12 duplex, 11:10 speed, 0 one.
`ifndef SGMAC_DEFS_VH
`define SGMAC_DEFS_VH
// ****************************************
// Register offsets
// ****************************************
`define SGMAC_OFF_CONTROL 8'h10
`define SGMAC_OFF_STATUS 8'h14
`define SGMAC_OFF_LOCAL 8'h18
`define SGMAC_OFF_PARTNER 8'h20
`define SGMAC_OFF_RESET 8'h04
// ****************************************
// Field positions
// ****************************************
`define SGMAC_CTL_ENABLE 0
`define SGMAC_CTL_RESTART 1
`define SGMAC_CTL_LOOPBACK 4
`define SGMAC_CTL_MASTER 5
`define SGMAC_RST_DATAPATH 1
`define SGMAC_ST_LINK 0
`define SGMAC_ST_FAULT 1
`define SGMAC_ST_DONE 2
`define SGMAC_ST_LOCK 4
`define SGMAC_ST_SIGNAL 5
`define SGMAC_AB_LINK 15
`define SGMAC_AB_ACK 14
`define SGMAC_AB_DUPLEX 12
`define SGMAC_AB_SPD_HI 11
`define SGMAC_AB_SPD_LO 10
`define SGMAC_SPD_GIG 2'h2
// ****************************************
// Reset values and timing
// ****************************************
`define SGMAC_CTL_RESET 6'h00
`define SGMAC_AB_RESET 16'h0001
`define SGMAC_ACK_CYCLES 4'h3
`endif

// >>> sgmac_sync.v
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module sgmac_sync (
    input wire clk_sys,
    input wire reset_n,
    input wire din,
    output reg dout
);
    reg stage1;
    // First stage feeds only the second
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

// >>> sgmac_properties.sv
// Assertion checker for the port control block
`timescale 1ns/100ps
`default_nettype none
module sgmac_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] local_config,
    input wire logic config_send,
    input wire logic loopback_on,
    input wire logic link_full_duplex,
    input wire logic [1:0] link_speed
);
    logic mst;
    logic srd;
    wire cw = reg_sel && reg_wr && reg_addr == 8'h10;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mst <= 1'b0;
            srd <= 1'b0;
        end else begin
            srd <= reg_sel && !reg_wr && reg_addr == 8'h14;
            mst <= cw ? reg_wdata[5] : mst;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_ctl; reg_sel && !reg_wr && reg_addr == 8'h10 |=>
        reg_rdata[31:6] == 26'h0; endproperty
    a_ctl: assert property (p_ctl) else $error("ctl");
    property p_lb; cw |-> ##2
        loopback_on == $past(reg_wdata[4], 2); endproperty
    a_lb: assert property (p_lb) else $error("loop");
    property p_en; cw && !reg_wdata[0] |-> ##3 !config_send; endproperty
    a_en: assert property (p_en) else $error("enable");
    property p_mst; srd && reg_rdata[2] && mst |->
        {link_full_duplex, link_speed} == local_config[12:10]; endproperty
    a_mst: assert property (p_mst) else $error("master");
    property p_flt; srd |-> reg_rdata[1] ==
        (reg_rdata[2] && !link_full_duplex && link_speed == 2'h2); endproperty
    a_flt: assert property (p_flt) else $error("fault");
    property p_lnk; srd && reg_rdata[0] |-> reg_rdata[2]; endproperty
    a_lnk: assert property (p_lnk) else $error("link");
    property p_dn; srd && reg_rdata[2] |-> config_send; endproperty
    a_dn: assert property (p_dn) else $error("done");
    property p_ab; config_send |-> local_config[0]; endproperty
    a_ab: assert property (p_ab) else $error("ability");
    property p_ack; $rose(config_send) |-> !local_config[14]; endproperty
    a_ack: assert property (p_ack) else $error("early ack");
endmodule
bind sgmac_ctrl sgmac_chk u_sgmac_chk (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_sel(reg_sel),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .local_config(local_config),
    .config_send(config_send),
    .loopback_on(loopback_on),
    .link_full_duplex(link_full_duplex),
    .link_speed(link_speed)
);
`default_nettype wire

// >>> sgmac_peer.sv
// Behavioural link peer
`timescale 1ns/100ps
`default_nettype none
module sgmac_peer (
    input wire logic clk_sys,
    input wire logic config_send,
    input wire logic [15:0] local_config,
    input wire logic [15:0] ability,
    input wire logic lock_on,
    output logic serdes_lock,
    output logic partner_config_valid,
    output logic [15:0] partner_config
);
    logic [15:0] n = 16'h0;
    always @(posedge clk_sys) begin
        n <= n + 16'h1;
        serdes_lock <= lock_on;
        partner_config_valid <= config_send;
        if (!config_send)
            partner_config <= ~ability ^ n; // Idle word never holds still
        // Acks on a valid device word; waiting for the device ack deadlocks
        else if (local_config[0] && !n[4])
            partner_config <= ability | 16'h4001;
        else
            partner_config <= ability | 16'h0001; // Slow phase, no ack
    end
endmodule
`default_nettype wire

// >>> sgmii_autoneg_ctrl_status_tb_top.sv
// Self-checking bench for the port control block
`timescale 1ns/100ps
`default_nettype none
module sgmii_autoneg_ctrl_status_tb_top;
    logic clk_sys = 0, reset_n = 0, sel = 0, wr = 0, sig = 0, lck = 0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wd = 32'h0, rdat, rd;
    logic [15:0] ab = 16'h1, lc, pc;
    logic lk, vld, cs, lb, dr, fd, ack;
    logic [1:0] sp;
    int num_errors = 0, n_tests = 0, lw, f;
    sgmac_ctrl u_sgmac_ctrl (.clk_sys, .reset_n, .reg_sel(sel), .reg_wr(wr),
        .reg_addr(adr), .reg_wdata(wd), .reg_rdata(rdat), .reg_ack(ack),
        .fiber_signal_present(sig), .serdes_lock(lk),
        .partner_config_valid(vld), .partner_config(pc), .local_config(lc),
        .config_send(cs), .loopback_on(lb), .datapath_reset(dr),
        .link_full_duplex(fd), .link_speed(sp));
    sgmac_peer u_sgmac_peer (.clk_sys, .config_send(cs), .local_config(lc),
        .ability(ab), .lock_on(lck), .serdes_lock(lk),
        .partner_config_valid(vld), .partner_config(pc));
    task automatic chk(input logic [31:0] got, input int e);
        n_tests++;
        if (got !== 32'(e)) begin
            num_errors++;
            $display("ERROR %0t got %h want %h", $time, got, e);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input int d);
        sel <= 1;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk_sys);
        sel <= 0;
        @(posedge clk_sys);
        rd = ack === 1'b1 ? rdat : 32'hx;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial forever #5 clk_sys = ~clk_sys;
    initial begin
        #100000 num_errors++;
        final_report();
    end
    initial begin
        void'($urandom(68));
        repeat (2) @(posedge clk_sys);
        reset_n <= 1;
        acc(1, 8'h14, -1);
        acc(0, 8'h14, 0);
        chk(rd, 0);
        acc(0, 8'h18, 0);
        chk(rd, 1);
        acc(1, 8'h04, 2);
        acc(1, 8'h10, 32'hffff_ffd2);
        acc(0, 8'h10, 0);
        chk(rd, 8'h12);
        chk({lb, dr}, 2'h3);
        acc(1, 8'h04, 0);
        for (int m = 0; m < 6; m++) begin
            lw = 16'h8001 | m % 3 << 10 | m % 2 << 12;
            f = 16'h8001 | $urandom_range(2) << 10 | $urandom_range(1) << 12;
            ab <= 16'(m < 3 ? f : lw);
            sig <= 1'($urandom);
            lck <= 1;
            acc(1, 8'h18, m < 3 ? lw : f);
            acc(1, 8'h10, m < 3 ? 8'h21 : 8'h01);
            for (int i = 0; i < 80 && rd[2] !== 1'b1; i++)
                acc(0, 8'h14, 0);
            f = m == 2;
            chk(rd, sig << 5 | 8'h14 | f << 1 | !f);
            chk({fd, sp}, lw[12:10]);
            acc(0, 8'h20, 0);
            chk(rd & 32'hbfff, ab);
            acc(1, 8'h10, 3);
            acc(1, 8'h10, 1);
            acc(0, 8'h14, 0);
            chk(rd, sig << 5 | 8'h10);
            for (int i = 0; i < 80 && rd[2] !== 1'b1; i++)
                acc(0, 8'h14, 0);
            chk(rd[2], 1);
            lck <= 0;
            repeat (3) acc(0, 8'h14, 0);
            chk(rd, sig << 5);
        end
        final_report();
    end
endmodule
`default_nettype wire
